/* File: hdl/vtp_pkg.sv */
// package of constants and types for the vector table placement block
// Notes on behaviour
// R01 - select clear: interrupt vectors come from the start of program flash
// R02 - select set: vectors move to the start of the boot-loader section
// R03 - relocated vector address is table address plus boot section start
// R04 - fuse unprogrammed, 4K boot, select set: reset 0, vectors $3802-$3828
// R05 - fuse programmed, 4K boot, select clear: reset $3800, vectors at $002
// R06 - fuse programmed, 4K boot, select set: reset $3800, vectors from $3802
// R07 - software sets unlock, then within four cycles writes select, unlock 0
// R08 - select writes are ignored unless unlock is set within four cycles
// R09 - interrupts blocked from unlock until the instruction after select write
// R10 - with no select write, interrupts stay blocked four cycles
// R11 - the global interrupt enable flag is left untouched by the blocking
// R12 - unlock clears four cycles after set, or at once on select write
// R13 - vectors in boot and app-side lock programmed: block while in app code
// R14 - vectors in app and boot-side lock programmed: block while in boot code
// R15 - software changes placement before enabling any interrupt source
package vtp_pkg;
    localparam logic [3:0] VTP_CTRL_ADDR = 4'h0;
    localparam logic [3:0] VTP_STAT_ADDR = 4'h4;
    localparam int VTP_SEL_BIT = 1;
    localparam int VTP_UNLOCK_BIT = 0;
    localparam int VTP_EXT0_BIT = 6;
    localparam int VTP_EXT1_BIT = 7;
    localparam int VTP_EXT2_BIT = 5;
    localparam logic [7:0] VTP_CTRL_RESET = 8'h00;
    localparam logic [7:0] VTP_CTRL_RW_MASK = 8'he3;
    localparam int VTP_UNLOCK_CYCLES = 4;
    localparam logic [2:0] VTP_WINDOW_RESET = 3'h0;
    localparam logic [13:0] VTP_TABLE_BASE = 14'h0000;
    localparam logic [13:0] VTP_FIRST_VECTOR = 14'h0002;
    localparam logic [13:0] VTP_LAST_VECTOR = 14'h0028;
    // word addresses of the boot section start, indexed by the size fuses
    localparam logic [13:0] VTP_BOOT_4K = 14'h3800;
    localparam logic [13:0] VTP_BOOT_2K = 14'h3c00;
    localparam logic [13:0] VTP_BOOT_1K = 14'h3e00;
    localparam logic [13:0] VTP_BOOT_512 = 14'h3f00;
    localparam logic [1:0] VTP_SZ_4K = 2'h0;
    localparam logic [1:0] VTP_SZ_2K = 2'h1;
    localparam logic [1:0] VTP_SZ_1K = 2'h2;

    typedef enum logic [1:0] {
        VTP_IDLE,
        VTP_OPEN,
        VTP_TRAIL
    } vtp_phase_e;

    typedef struct packed {
        logic boot_reset_fuse;
        logic [1:0] boot_size_fuses;
        logic app_side_boot_lock;
        logic boot_side_boot_lock;
    } vtp_fuse_s;

    typedef struct packed {
        logic [13:0] reset_addr;
        logic [13:0] vector_base;
        logic [13:0] vector_last;
    } vtp_place_s;
endpackage

/* File: hdl/vtp_map.sv */
// vector placement map: reset and vector addresses from fuses and select
`timescale 1ns/1ps
module vtp_map
    import vtp_pkg::*;
(
    input wire logic vector_base_select,
    input wire vtp_fuse_s fuses,
    output vtp_place_s place
);
    logic [13:0] boot_start;

    always_comb begin
        if (fuses.boot_size_fuses == VTP_SZ_4K) begin
            boot_start = VTP_BOOT_4K;
        end else if (fuses.boot_size_fuses == VTP_SZ_2K) begin
            boot_start = VTP_BOOT_2K;
        end else if (fuses.boot_size_fuses == VTP_SZ_1K) begin
            boot_start = VTP_BOOT_1K;
        end else begin
            boot_start = VTP_BOOT_512;
        end
        // programmed fuse reads as zero
        place.reset_addr = fuses.boot_reset_fuse ? VTP_TABLE_BASE
                                                 : boot_start; // R04 R05 R06
        if (vector_base_select) begin
            place.vector_base = boot_start + VTP_FIRST_VECTOR; // R02 R03 R04
            place.vector_last = boot_start + VTP_LAST_VECTOR; // R03 R06
        end else begin
            place.vector_base = VTP_TABLE_BASE + VTP_FIRST_VECTOR; // R01 R05
            place.vector_last = VTP_TABLE_BASE + VTP_LAST_VECTOR; // R01
        end
    end
endmodule // vtp_map

/* File: hdl/vtp_top.sv */
// vector table placement block with its avalon control register
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
module vtp_top
    import vtp_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    input wire logic boot_reset_fuse,
    input wire logic [1:0] boot_size_fuses,
    input wire logic app_side_boot_lock,
    input wire logic boot_side_boot_lock,
    input wire logic exec_in_boot,
    input wire logic instr_done,
    output logic irq_block,
    output logic vector_base_select,
    output logic ext_irq_zero_enable,
    output logic ext_irq_one_enable,
    output logic ext_irq_two_enable,
    output logic [13:0] reset_addr,
    output logic [13:0] vector_base,
    output logic [13:0] vector_last
);
    typedef struct packed {
        logic [7:0] ctrl;
        vtp_phase_e phase;
        logic [2:0] window;
        logic waitreq;
        logic [31:0] rdata;
        logic [1:0] resp;
        logic block;
        vtp_place_s place;
    } vtp_state_s;

    vtp_state_s state_q;
    vtp_state_s state_d;
    vtp_fuse_s fuses;
    vtp_place_s place_next;
    logic [7:0] next_ctrl;
    logic access;
    logic hit_ctrl;
    logic hit_stat;
    logic do_write;
    logic lock_block;

    assign fuses.boot_reset_fuse = boot_reset_fuse;
    assign fuses.boot_size_fuses = boot_size_fuses;
    assign fuses.app_side_boot_lock = app_side_boot_lock;
    assign fuses.boot_side_boot_lock = boot_side_boot_lock;

    vtp_map u_map (
        .vector_base_select(next_ctrl[VTP_SEL_BIT]),
        .fuses(fuses),
        .place(place_next)
    );

    always_comb begin
        state_d = state_q;
        next_ctrl = state_q.ctrl;
        // one wait state: a request is seen, then answered one cycle later
        access = (avs_read || avs_write) && state_q.waitreq;
        hit_ctrl = 1'b0;
        hit_stat = 1'b0;
        if (avs_address == VTP_CTRL_ADDR) begin
            hit_ctrl = 1'b1;
        end else if (avs_address == VTP_STAT_ADDR) begin
            hit_stat = 1'b1;
        end
        // writes land at the answer edge, where the master sees the transfer
        do_write = avs_write && !state_q.waitreq && hit_ctrl &&
                   avs_byteenable[0];
        state_d.waitreq = !access;
        // the response stands until the next request is seen
        if (access) begin
            state_d.resp = (hit_ctrl || hit_stat) ? 2'h0 : 2'h2;
        end

        // unlock window runs its four cycles unless a bus write ends it with select or restarts it
        if (state_q.phase == VTP_OPEN) begin
            if (state_q.window == 3'(VTP_UNLOCK_CYCLES - 1)) begin
                next_ctrl[VTP_UNLOCK_BIT] = 1'b0; // R12
                state_d.phase = VTP_IDLE; // R10
            end
            state_d.window = state_q.window + 3'h1;
        end

        case (state_q.phase)
            VTP_TRAIL: begin
                // hold the block through the instruction after the write
                if (instr_done) begin
                    state_d.phase = VTP_IDLE; // R09
                end
            end
            default: begin
            end
        endcase

        if (do_write) begin
            next_ctrl[VTP_EXT0_BIT] = avs_writedata[VTP_EXT0_BIT];
            next_ctrl[VTP_EXT1_BIT] = avs_writedata[VTP_EXT1_BIT];
            next_ctrl[VTP_EXT2_BIT] = avs_writedata[VTP_EXT2_BIT];
            if (state_q.ctrl[VTP_UNLOCK_BIT] &&
                !avs_writedata[VTP_UNLOCK_BIT]) begin
                next_ctrl[VTP_SEL_BIT] = avs_writedata[VTP_SEL_BIT]; // R08
                next_ctrl[VTP_UNLOCK_BIT] = 1'b0; // R12
                state_d.phase = VTP_TRAIL; // R09
            end else if (avs_writedata[VTP_UNLOCK_BIT]) begin
                // a fresh unlock restarts the window
                next_ctrl[VTP_UNLOCK_BIT] = 1'b1;
                state_d.phase = VTP_OPEN; // R09
                state_d.window = VTP_WINDOW_RESET;
            end
        end
        state_d.ctrl = next_ctrl & VTP_CTRL_RW_MASK;

        if (access && avs_read) begin
            if (hit_ctrl) begin
                state_d.rdata = {24'h000000, state_q.ctrl};
            end else if (hit_stat) begin
                state_d.rdata = {24'h000000, 5'h00, exec_in_boot,
                                 state_q.phase != VTP_IDLE, state_q.block};
            end else begin
                state_d.rdata = 32'h00000000;
            end
        end

        // lock bits keep the foreign section from taking interrupts
        lock_block = (next_ctrl[VTP_SEL_BIT] && app_side_boot_lock &&
                      !exec_in_boot) || // R13
                     (!next_ctrl[VTP_SEL_BIT] && boot_side_boot_lock &&
                      exec_in_boot); // R14
        // gate only; the global enable flag lives in the core, untouched
        state_d.block = (state_d.phase != VTP_IDLE) || lock_block; // R11
        state_d.place = place_next;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q.ctrl <= VTP_CTRL_RESET;
            state_q.phase <= VTP_IDLE;
            state_q.window <= VTP_WINDOW_RESET;
            state_q.waitreq <= 1'b1;
            state_q.rdata <= 32'h00000000;
            state_q.resp <= 2'h0;
            state_q.block <= 1'b0;
            state_q.place <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign avs_readdata = state_q.rdata;
    assign avs_response = state_q.resp;
    assign avs_waitrequest = state_q.waitreq;
    assign irq_block = state_q.block;
    assign vector_base_select = state_q.ctrl[VTP_SEL_BIT];
    assign ext_irq_zero_enable = state_q.ctrl[VTP_EXT0_BIT];
    assign ext_irq_one_enable = state_q.ctrl[VTP_EXT1_BIT];
    assign ext_irq_two_enable = state_q.ctrl[VTP_EXT2_BIT];
    assign reset_addr = state_q.place.reset_addr;
    assign vector_base = state_q.place.vector_base;
    assign vector_last = state_q.place.vector_last;
endmodule // vtp_top

/* File: test/vtp_top_sva.sv */
// concurrent checks on the vector placement block ports
`timescale 1ns/1ps
module vtp_top_sva
    import vtp_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic [1:0] avs_response,
    input wire logic boot_reset_fuse,
    input wire logic [1:0] boot_size_fuses,
    input wire logic app_side_boot_lock,
    input wire logic boot_side_boot_lock,
    input wire logic exec_in_boot,
    input wire logic irq_block,
    input wire logic vector_base_select,
    input wire logic [13:0] reset_addr,
    input wire logic [13:0] vector_base,
    input wire logic [13:0] vector_last
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic [13:0] boot;
    logic lock, req, unl, odd;
    assign boot = boot_size_fuses == 2'h0 ? VTP_BOOT_4K :
        boot_size_fuses == 2'h1 ? VTP_BOOT_2K :
        boot_size_fuses == 2'h2 ? VTP_BOOT_1K : VTP_BOOT_512;
    assign lock = vector_base_select ? app_side_boot_lock && !exec_in_boot
        : boot_side_boot_lock && exec_in_boot;
    assign req = (avs_read || avs_write) && avs_waitrequest;
    assign unl = req && avs_write && avs_address == VTP_CTRL_ADDR &&
        avs_byteenable[0] && avs_writedata[1:0] == 2'h1;
    assign odd = avs_address != VTP_CTRL_ADDR &&
        avs_address != VTP_STAT_ADDR;
    a_one_wait: assert property (req |=> !avs_waitrequest)
        else $error("answer late");
    a_unmapped_resp: assert property (!avs_waitrequest && req == 1'b0 &&
        (avs_read || avs_write) && odd |-> avs_response == 2'h2)
        else $error("bad unmapped response");
    a_vec_last: assert property (
        !$past(reset) && $stable(vector_base_select) &&
        $stable(boot_size_fuses) |-> vector_last ==
        (vector_base_select ? boot : VTP_TABLE_BASE) + VTP_LAST_VECTOR)
        else $error("vector end wrong");
    a_vec_base: assert property (
        !$past(reset) && $stable(vector_base_select) &&
        $stable(boot_size_fuses) |-> vector_base ==
        (vector_base_select ? boot : VTP_TABLE_BASE) + VTP_FIRST_VECTOR)
        else $error("vector start wrong");
    a_reset_addr: assert property (
        !$past(reset) && $stable(boot_reset_fuse) &&
        $stable(boot_size_fuses) |->
        reset_addr == (boot_reset_fuse ? VTP_TABLE_BASE : boot))
        else $error("reset address wrong");
    a_unlock_block: assert property (unl |-> ##[1:2] irq_block)
        else $error("unlock left interrupts open");
    a_block_expiry: assert property (
        unl ##2 (!avs_write && !lock)[*7] |-> !irq_block)
        else $error("block outlived window");
    a_select_guard: assert property ($changed(vector_base_select) |->
        $past(irq_block) || $past(irq_block, 2))
        else $error("select moved without unlock");
    a_lock_block: assert property (
        lock && $past(lock) && !$past(reset) |-> irq_block)
        else $error("lock did not block");
endmodule // vtp_top_sva
bind vtp_top vtp_top_sva i_vtp_top_sva (.*);

/* File: test/test_vector_table_placement.sv */
// self-checking bench for the vector placement block
`timescale 1ns/1ps
module test_vector_table_placement;
    import vtp_pkg::*;
    logic clk = 0;
    logic reset = 1;
    logic avs_read = 0;
    logic avs_write = 0;
    logic [3:0] avs_address = 0;
    logic [3:0] avs_byteenable = 0;
    logic [31:0] avs_writedata = 0;
    logic boot_reset_fuse = 1;
    logic [1:0] boot_size_fuses = 0;
    logic app_side_boot_lock = 0;
    logic boot_side_boot_lock = 0;
    logic exec_in_boot = 0;
    logic instr_done = 0;
    logic [31:0] avs_readdata, rdata;
    logic [1:0] avs_response, rresp;
    logic avs_waitrequest, irq_block, vector_base_select;
    logic ext_irq_zero_enable, ext_irq_one_enable, ext_irq_two_enable;
    logic [13:0] reset_addr, vector_base, vector_last, boot;
    int mismatches = 0;
    int checks_done = 0;
    vtp_top i_vtp_top (.*);
    always #2.5 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        if (mismatches == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one idle edge after release so no signal is driven twice per step
    task automatic bus(input logic wr, input logic [3:0] a,
            input logic [7:0] d, input logic [3:0] be);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        // no local limit: only the watchdog ends a wait that never answers
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        rresp = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask
    task automatic w(input logic [7:0] d);
        bus(1'b1, VTP_CTRL_ADDR, d, 4'h1);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h00, 4'hf);
        chk(rdata, e);
    endtask
    task automatic pulse();
        instr_done <= 1'b1;
        @(posedge clk);
        instr_done <= 1'b0;
        tick(2);
    endtask
    task automatic place();
        for (int f = 0; f < 2; f++) begin
            for (int s = 0; s < 4; s++) begin
                boot_reset_fuse <= f[0];
                boot_size_fuses <= s[1:0];
                tick(3);
                boot = s == 0 ? VTP_BOOT_4K : s == 1 ? VTP_BOOT_2K :
                    s == 2 ? VTP_BOOT_1K : VTP_BOOT_512;
                chk(reset_addr, f ? 14'h0 : boot);
                boot = vector_base_select ? boot : 14'h0;
                chk(vector_last, boot + VTP_LAST_VECTOR);
                chk(vector_base, boot + VTP_FIRST_VECTOR);
            end
        end
    endtask
    initial begin
        tick(10);
        reset <= 1'b0;
        tick(1);
        rd(VTP_CTRL_ADDR, 32'h0);
        bus(1'b1, VTP_CTRL_ADDR, 8'h1f, 4'h0);
        w(8'h02);
        rd(VTP_CTRL_ADDR, 32'h0);
        place();
        // sources stay disabled until the table has moved
        w(8'h01);
        chk(irq_block, 1'b1);
        w(8'h02);
        rd(VTP_CTRL_ADDR, 32'h02);
        chk(irq_block, 1'b1);
        pulse();
        chk(irq_block, 1'b0);
        w(8'he2);
        rd(VTP_CTRL_ADDR, 32'he2);
        chk({ext_irq_one_enable, ext_irq_zero_enable, ext_irq_two_enable},
            3'h7);
        place();
        app_side_boot_lock <= 1'b1;
        tick(3);
        chk(irq_block, 1'b1);
        exec_in_boot <= 1'b1;
        tick(3);
        chk(irq_block, 1'b0);
        rd(VTP_STAT_ADDR, 32'h4);
        app_side_boot_lock <= 1'b0;
        w(8'h01);
        tick(8);
        chk(irq_block, 1'b0);
        rd(VTP_CTRL_ADDR, 32'h02);
        w(8'h00);
        rd(VTP_CTRL_ADDR, 32'h02);
        w(8'h01);
        w(8'h00);
        pulse();
        chk(vector_base_select, 1'b0);
        boot_side_boot_lock <= 1'b1;
        tick(3);
        chk(irq_block, 1'b1);
        exec_in_boot <= 1'b0;
        tick(3);
        chk(irq_block, 1'b0);
        bus(1'b1, 4'h8, 8'hff, 4'hf);
        chk(rresp, 2'h2);
        rd(4'h8, 32'h0);
        chk(rresp, 2'h2);
        complete_run();
    end
    initial begin
        tick(6000);
        mismatches++;
        complete_run();
    end
endmodule // test_vector_table_placement
